// ### slata_top.sv
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "slata_cfg.svh"

module slata_top
	import slata_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [31:0] dest_data,
	output logic dest_write,
	output logic flag_n,
	output logic flag_z,
	output logic flag_c,
	output logic flag_v,
	output logic flags_write
);

	// The lane split below is fixed to a 32-bit word; other widths are refused.
	if (DATA_W != 32) begin : g_width_check
		$error("slata_top serves only a 32-bit data path");
	end

	// Register map, byte addressed, full words only:
	//   first operand, read and write;
	//   second operand, read and write, holding the already shifted flexible operand;
	//   command, write only: operation code, shifter carry valid, shifter carry;
	//   result, read only: the last value written to the destination;
	//   flags, read and write: negative, zero, carry and overflow;
	//   status, read only: last command refused, wrote the destination, was a test.
	// Writes to read-only or unmapped words are dropped; unmapped reads return zero.

	// The command fields share one word and must not overlap one another.
	if ((`SLATA_CMD_CV_BIT < `SLATA_CMD_OP_LSB + 4)
			|| (`SLATA_CMD_CIN_BIT < `SLATA_CMD_OP_LSB + 4)
			|| (`SLATA_CMD_CV_BIT == `SLATA_CMD_CIN_BIT)) begin : g_cmd_check
		$error("slata_top command fields overlap");
	end

	// The four flags must sit in distinct bits of their word.
	if ((`SLATA_FLG_N_BIT == `SLATA_FLG_Z_BIT)
			|| (`SLATA_FLG_N_BIT == `SLATA_FLG_C_BIT)
			|| (`SLATA_FLG_N_BIT == `SLATA_FLG_V_BIT)
			|| (`SLATA_FLG_Z_BIT == `SLATA_FLG_C_BIT)
			|| (`SLATA_FLG_Z_BIT == `SLATA_FLG_V_BIT)
			|| (`SLATA_FLG_C_BIT == `SLATA_FLG_V_BIT)) begin : g_flag_check
		$error("slata_top flag fields overlap");
	end

	logic [31:0] opa_reg;
	logic [31:0] opb_reg;
	logic [31:0] dest_reg;
	logic dest_write_reg;
	logic flag_n_reg;
	logic flag_z_reg;
	logic flag_c_reg;
	logic flag_v_reg;
	logic flags_write_reg;
	logic illegal_reg;
	logic [31:0] rdata_reg;

	logic exec;
	logic [3:0] op_code;
	logic shift_carry_valid;
	logic shift_carry;

	logic [31:0] quad_wrap;
	logic [31:0] quad_half;
	logic [31:0] dual_wrap;
	logic [31:0] dual_half;

	logic [15:0] s_top_sum;
	logic [15:0] s_top_dif;
	logic [15:0] s_bot_sum;
	logic [15:0] s_bot_dif;
	logic [15:0] u_top_sum;
	logic [15:0] u_top_dif;
	logic [15:0] u_bot_sum;
	logic [15:0] u_bot_dif;

	logic [31:0] test_value;
	logic [31:0] res_next;
	logic writes_dest;
	logic writes_flags;
	logic is_test;
	logic is_illegal;
	logic is_test_last_reg;
	logic dest_last_reg;
	logic test_upd;
	logic dest_upd;
	logic flag_sw_wr;
	logic [31:0] flags_word;
	logic [31:0] status_word;

	// An operation is launched by the write to the command word itself, so the
	// operands must already sit in their registers when the command is written.
	assign exec = reg_wr && (reg_addr == `SLATA_OFF_CMD);
	assign op_code = reg_wdata[`SLATA_CMD_OP_LSB +: 4];
	assign shift_carry_valid = reg_wdata[`SLATA_CMD_CV_BIT];
	assign shift_carry = reg_wdata[`SLATA_CMD_CIN_BIT];

	// Each byte lane owns its own ninth bit, so no carry reaches the next lane.
	for (genvar g = 0; g < 4; g++) begin : g_byte_lane
		logic [8:0] sum;
		assign sum = {1'b0, opa_reg[8*g +: 8]} + {1'b0, opb_reg[8*g +: 8]};
		assign quad_wrap[8*g +: 8] = sum[7:0];
		assign quad_half[8*g +: 8] = sum[8:1];
	end

	for (genvar h = 0; h < 2; h++) begin : g_half_lane
		logic [16:0] sum;
		assign sum = {1'b0, opa_reg[16*h +: 16]} + {1'b0, opb_reg[16*h +: 16]};
		assign dual_wrap[16*h +: 16] = sum[15:0];
		assign dual_half[16*h +: 16] = sum[16:1];
	end

	// Halfword views of the operands, named for the exchange pairings below.
	logic [15:0] a_hi;
	logic [15:0] a_lo;
	logic [15:0] b_hi;
	logic [15:0] b_lo;

	assign a_hi = opa_reg[31:16];
	assign a_lo = opa_reg[15:0];
	assign b_hi = opb_reg[31:16];
	assign b_lo = opb_reg[15:0];

	// Signed and unsigned exchange forms share the same bits once wrapped to
	// 16 bits; both are kept so each reads as its own operation.
	assign s_top_sum = 16'($signed(a_hi) + $signed(b_lo));
	assign s_bot_dif = 16'($signed(a_lo) - $signed(b_hi));
	assign s_bot_sum = 16'($signed(a_lo) + $signed(b_hi));
	assign s_top_dif = 16'($signed(a_hi) - $signed(b_lo));
	assign u_bot_dif = a_lo - b_hi;
	assign u_top_sum = a_hi + b_lo;
	assign u_bot_sum = a_lo + b_hi;
	assign u_top_dif = a_hi - b_lo;

	always_comb begin
		res_next = dest_reg;
		writes_dest = 1'b0;
		writes_flags = 1'b0;
		is_test = 1'b0;
		is_illegal = 1'b0;
		test_value = opa_reg & opb_reg;
		unique case (op_code)
			SLATA_OP_NOP: begin
				writes_dest = 1'b0;
			end
			SLATA_OP_SIGNED_ADD_SUB_EXCHANGE: begin
				res_next = {s_top_sum, s_bot_dif};
				writes_dest = 1'b1;
			end
			SLATA_OP_SIGNED_SUB_ADD_EXCHANGE: begin
				res_next = {s_top_dif, s_bot_sum};
				writes_dest = 1'b1;
			end
			SLATA_OP_UNSIGNED_ADD_SUB_EXCHANGE: begin
				res_next = {u_top_sum, u_bot_dif};
				writes_dest = 1'b1;
			end
			SLATA_OP_UNSIGNED_SUB_ADD_EXCHANGE: begin
				res_next = {u_top_dif, u_bot_sum};
				writes_dest = 1'b1;
			end
			SLATA_OP_UNSIGNED_DUAL_HALF_ADD: begin
				res_next = dual_wrap;
				writes_dest = 1'b1;
			end
			SLATA_OP_UNSIGNED_QUAD_BYTE_ADD: begin
				res_next = quad_wrap;
				writes_dest = 1'b1;
			end
			SLATA_OP_UNSIGNED_DUAL_HALF_HALVING_ADD: begin
				res_next = dual_half;
				writes_dest = 1'b1;
			end
			SLATA_OP_UNSIGNED_QUAD_BYTE_HALVING_ADD: begin
				res_next = quad_half;
				writes_dest = 1'b1;
			end
			SLATA_OP_BIT_TEST_AND: begin
				test_value = opa_reg & opb_reg;
				writes_flags = 1'b1;
				is_test = 1'b1;
			end
			SLATA_OP_EQUIVALENCE_TEST_XOR: begin
				test_value = opa_reg ^ opb_reg;
				writes_flags = 1'b1;
				is_test = 1'b1;
			end
			default: begin
				is_illegal = 1'b1;
			end
		endcase
	end

	// Decoded strobes shared by the state blocks below.
	assign test_upd = exec && writes_flags;
	assign dest_upd = exec && writes_dest;
	assign flag_sw_wr = reg_wr && (reg_addr == `SLATA_OFF_FLAGS);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opa_reg <= `SLATA_RST_WORD;
		end else if (reg_wr && (reg_addr == `SLATA_OFF_OPA)) begin
			opa_reg <= reg_wdata;
		end
	end

	// The second operand arrives already shifted; no shifter sits in this block.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opb_reg <= `SLATA_RST_WORD;
		end else if (reg_wr && (reg_addr == `SLATA_OFF_OPB)) begin
			opb_reg <= reg_wdata;
		end
	end

	// Test operations keep the destination untouched and raise no write pulse.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dest_reg <= `SLATA_RST_WORD;
		end else if (dest_upd) begin
			dest_reg <= res_next;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dest_write_reg <= `SLATA_RST_BIT;
		end else begin
			dest_write_reg <= dest_upd;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_write_reg <= `SLATA_RST_BIT;
		end else begin
			flags_write_reg <= test_upd;
		end
	end

	// Only the two tests reach the flags; lane and exchange operations leave
	// them as they were, and software may preset them through their register.
	// A test and a software write cannot meet in one cycle, since both need the
	// one write strobe, yet negative, zero and carry still give the test priority.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_n_reg <= `SLATA_RST_BIT;
		end else if (test_upd) begin
			flag_n_reg <= test_value[31];
		end else if (flag_sw_wr) begin
			flag_n_reg <= reg_wdata[`SLATA_FLG_N_BIT];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_z_reg <= `SLATA_RST_BIT;
		end else if (test_upd) begin
			flag_z_reg <= (test_value == 32'h0000_0000);
		end else if (flag_sw_wr) begin
			flag_z_reg <= reg_wdata[`SLATA_FLG_Z_BIT];
		end
	end

	// The carry follows the shifter only when the command marks its carry as
	// valid; a test without that mark leaves the carry as it was.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_c_reg <= `SLATA_RST_BIT;
		end else if (test_upd) begin
			if (shift_carry_valid) begin
				flag_c_reg <= shift_carry;
			end
		end else if (flag_sw_wr) begin
			flag_c_reg <= reg_wdata[`SLATA_FLG_C_BIT];
		end
	end

	// Overflow is only ever loaded by software; no operation here drives it.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_v_reg <= `SLATA_RST_BIT;
		end else if (flag_sw_wr) begin
			flag_v_reg <= reg_wdata[`SLATA_FLG_V_BIT];
		end
	end

	// Status of the last command; a refused code counts as a command too.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			illegal_reg <= `SLATA_RST_BIT;
		end else if (exec) begin
			illegal_reg <= is_illegal;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			is_test_last_reg <= `SLATA_RST_BIT;
		end else if (exec) begin
			is_test_last_reg <= is_test;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dest_last_reg <= `SLATA_RST_BIT;
		end else if (exec) begin
			dest_last_reg <= writes_dest;
		end
	end

	// Flag and status words are built from their field positions, so the read
	// mux below stays a plain selection.
	always_comb begin
		flags_word = `SLATA_RST_WORD;
		flags_word[`SLATA_FLG_N_BIT] = flag_n_reg;
		flags_word[`SLATA_FLG_Z_BIT] = flag_z_reg;
		flags_word[`SLATA_FLG_C_BIT] = flag_c_reg;
		flags_word[`SLATA_FLG_V_BIT] = flag_v_reg;
	end

	always_comb begin
		status_word = `SLATA_RST_WORD;
		status_word[`SLATA_STS_ILLEGAL_BIT] = illegal_reg;
		status_word[`SLATA_STS_DEST_BIT] = dest_last_reg;
		status_word[`SLATA_STS_FLAGS_BIT] = is_test_last_reg;
	end

	// Read data stand for exactly the cycle after the read strobe.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= `SLATA_RST_WORD;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SLATA_OFF_OPA: begin
					rdata_reg <= opa_reg;
				end
				`SLATA_OFF_OPB: begin
					rdata_reg <= opb_reg;
				end
				`SLATA_OFF_RESULT: begin
					rdata_reg <= dest_reg;
				end
				`SLATA_OFF_FLAGS: begin
					rdata_reg <= flags_word;
				end
				`SLATA_OFF_STATUS: begin
					rdata_reg <= status_word;
				end
				default: begin
					rdata_reg <= `SLATA_RST_WORD;
				end
			endcase
		end else begin
			rdata_reg <= `SLATA_RST_WORD;
		end
	end

	assign reg_rdata = rdata_reg;
	assign dest_data = dest_reg;
	assign dest_write = dest_write_reg;
	assign flag_n = flag_n_reg;
	assign flag_z = flag_z_reg;
	assign flag_c = flag_c_reg;
	assign flag_v = flag_v_reg;
	assign flags_write = flags_write_reg;

endmodule

// ### slata_cfg.svh
`ifndef SLATA_CFG_SVH
`define SLATA_CFG_SVH
// How it works
// - Signed add-sub exchange: top half gets first top plus second bottom.
// - Signed add-sub exchange: bottom half gets first bottom minus second top.
// - Signed sub-add exchange: bottom half gets first bottom plus second top.
// - Signed sub-add exchange: top half gets first top minus second bottom.
// - Every halfword exchange operation leaves all condition flags alone.
// - Bit test ANDs first register with flexible operand, only for flags.
// - Equivalence test XORs first register with flexible operand, only for flags.
// - Test operations never write a destination; only flags may change.
// - Test operations: negative from bit 31, zero when all bits zero.
// - Test operations take shifter carry when supplied, else carry holds.
// - Test operations never touch the overflow flag.
// - After equivalence test, negative equals XOR of both sign bits.
// - Dual halfword add sums each 16-bit lane into its own half.
// - Quad byte add sums each 8-bit lane into its own byte.
// - Unsigned add-sub exchange: bottom gets first bottom minus second top.
// - Unsigned add-sub exchange: top gets first top plus second bottom.
// - Unsigned sub-add exchange: bottom gets first bottom plus second top.
// - Unsigned sub-add exchange: top gets first top minus second bottom.
// - Dual halfword halving add shifts each lane sum right one bit.
// - Quad byte halving add shifts each byte sum right one bit.
// - Lane adds and halving adds leave every condition flag unchanged.

`define SLATA_OFF_OPA 8'h00
`define SLATA_OFF_OPB 8'h04
`define SLATA_OFF_CMD 8'h08
`define SLATA_OFF_RESULT 8'h0C
`define SLATA_OFF_FLAGS 8'h10
`define SLATA_OFF_STATUS 8'h14

`define SLATA_CMD_OP_LSB 0
`define SLATA_CMD_CV_BIT 8
`define SLATA_CMD_CIN_BIT 9

`define SLATA_FLG_N_BIT 31
`define SLATA_FLG_Z_BIT 30
`define SLATA_FLG_C_BIT 29
`define SLATA_FLG_V_BIT 28

`define SLATA_STS_ILLEGAL_BIT 0
`define SLATA_STS_DEST_BIT 1
`define SLATA_STS_FLAGS_BIT 2

`define SLATA_RST_WORD 32'h0000_0000
`define SLATA_RST_BIT 1'h0
`endif

// ### slata_pkg.sv
package slata_pkg;
	typedef enum logic [3:0] {
		SLATA_OP_NOP = 4'h0,
		SLATA_OP_SIGNED_ADD_SUB_EXCHANGE = 4'h1,
		SLATA_OP_SIGNED_SUB_ADD_EXCHANGE = 4'h2,
		SLATA_OP_UNSIGNED_ADD_SUB_EXCHANGE = 4'h3,
		SLATA_OP_UNSIGNED_SUB_ADD_EXCHANGE = 4'h4,
		SLATA_OP_UNSIGNED_DUAL_HALF_ADD = 4'h5,
		SLATA_OP_UNSIGNED_QUAD_BYTE_ADD = 4'h6,
		SLATA_OP_UNSIGNED_DUAL_HALF_HALVING_ADD = 4'h7,
		SLATA_OP_UNSIGNED_QUAD_BYTE_HALVING_ADD = 4'h8,
		SLATA_OP_BIT_TEST_AND = 4'h9,
		SLATA_OP_EQUIVALENCE_TEST_XOR = 4'hA
	} slata_op_t;
endpackage

// ### slata_sva.sv
`timescale 1ns/1ns
module slata_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] dest_data,
	input wire logic dest_write,
	input wire logic flag_n,
	input wire logic flag_z,
	input wire logic flag_c,
	input wire logic flag_v,
	input wire logic flags_write
);
	logic [31:0] a_reg;
	logic [31:0] b_reg;
	logic [31:0] q_sum;
	logic [31:0] n_val;
	logic [31:0] x_val;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a_reg <= 32'h0;
		else if (reg_wr && reg_addr == 8'h00)
			a_reg <= reg_wdata;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			b_reg <= 32'h0;
		else if (reg_wr && reg_addr == 8'h04)
			b_reg <= reg_wdata;
	end
	assign n_val = a_reg & b_reg;
	assign x_val = a_reg ^ b_reg;
	// Each byte is summed on its own, so a carry can never leak upward.
	assign q_sum = {a_reg[31:24] + b_reg[31:24], a_reg[23:16] + b_reg[23:16],
		a_reg[15:8] + b_reg[15:8], a_reg[7:0] + b_reg[7:0]};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_cmd;
		reg_wr && reg_addr == 8'h08;
	endsequence
	sequence s_test;
		s_cmd ##0 (reg_wdata[3:0] == 4'h9 || reg_wdata[3:0] == 4'hA);
	endsequence
	sequence s_lane;
		s_cmd ##0 (reg_wdata[3:0] inside {[4'h1:4'h8]});
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_test_no_dest: assert property (s_test |=> !dest_write && $stable(dest_data))
		else $error("test operation wrote a destination");
	a_lane_keeps_flags: assert property (s_lane |=>
		dest_write && $stable({flag_n, flag_z, flag_c, flag_v}))
		else $error("lane operation disturbed flags");
	a_quad_sum: assert property (s_cmd ##0 reg_wdata[3:0] == 4'h6 |=>
		dest_data == $past(q_sum))
		else $error("quad byte sum wrong");
	a_xor_flags: assert property (s_cmd ##0 reg_wdata[3:0] == 4'hA |=>
		flag_n == $past(x_val[31]) && flag_z == ($past(x_val) == 32'h0))
		else $error("equivalence test flags wrong");
	a_and_flags: assert property (s_cmd ##0 reg_wdata[3:0] == 4'h9 |=>
		flag_n == $past(n_val[31]) && flag_z == ($past(n_val) == 32'h0))
		else $error("bit test flags wrong");
	a_v_untouched: assert property (flags_write |-> $stable(flag_v))
		else $error("test changed overflow");
	a_carry_rule: assert property (s_test |=>
		flag_c == ($past(reg_wdata[8]) ? $past(reg_wdata[9]) : $past(flag_c)))
		else $error("test carry wrong");
	a_test_pulse: assert property (s_test ##1 !reg_wr |-> flags_write ##1 !flags_write)
		else $error("flag update pulse wrong");
endmodule

bind slata_top slata_sva slata_sva_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.dest_data(dest_data), .dest_write(dest_write), .flag_n(flag_n), .flag_z(flag_z),
	.flag_c(flag_c), .flag_v(flag_v), .flags_write(flags_write));

// ### slata_tb_top.sv
`timescale 1ns/1ns
module slata_tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] dest_data;
	logic dest_write;
	logic flag_n;
	logic flag_z;
	logic flag_c;
	logic flag_v;
	logic flags_write;
	logic [31:0] last;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	slata_top slata_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dest_data(dest_data), .dest_write(dest_write), .flag_n(flag_n), .flag_z(flag_z),
		.flag_c(flag_c), .flag_v(flag_v), .flags_write(flags_write));
	task automatic close_out();
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// Runs one command and leaves time just after its result edge.
	// Operands are plain values; no stack pointer or program counter is named.
	task automatic exec(input logic [31:0] cmd, input logic [31:0] a, input logic [31:0] b);
		wr(8'h00, a);
		wr(8'h04, b);
		wr(8'h08, cmd);
		#1;
	endtask
	function automatic logic [31:0] flg();
		return {flag_n, flag_z, flag_c, flag_v, 28'h0};
	endfunction
	function automatic logic [31:0] expv(input logic [3:0] op, input logic [31:0] a,
		input logic [31:0] b);
		logic [31:0] r;
		logic [16:0] h;
		logic [8:0] s;
		r = 32'h0;
		case (op)
			4'h1, 4'h3: r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
			4'h2, 4'h4: r = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
			4'h5, 4'h7: for (int g = 0; g < 2; g++) begin
				h = a[16*g+:16] + b[16*g+:16];
				r[16*g+:16] = (op == 4'h7) ? h[16:1] : h[15:0];
			end
			default: for (int g = 0; g < 4; g++) begin
				s = a[8*g+:8] + b[8*g+:8];
				r[8*g+:8] = (op == 4'h8) ? s[8:1] : s[7:0];
			end
		endcase
		return r;
	endfunction
	task automatic t_reset();
		chk(dest_data, 32'h0);
		chk(flg(), 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h3C, 32'h0);
	endtask
	task automatic t_lanes();
		logic [31:0] av [2] = '{32'hFFFF_80FE, 32'h8001_7FFF};
		logic [31:0] bv [2] = '{32'h0001_8003, 32'hFFFF_0001};
		logic [31:0] e;
		wr(8'h10, 32'hD000_0000);
		for (int op = 1; op <= 8; op++) begin
			for (int k = 0; k < 2; k++) begin
				exec(op, av[k], bv[k]);
				e = expv(4'(op), av[k], bv[k]);
				chk({31'h0, dest_write}, 32'h1);
				chk(dest_data, e);
				chk(flg(), 32'hD000_0000);
				rd(8'h0C, e);
				rd(8'h14, 32'h2);
			end
		end
	endtask
	task automatic t_tests();
		logic [31:0] cv [5] = '{32'h9, 32'h10A, 32'h30A, 32'h109, 32'h309};
		logic [31:0] av [5] = '{32'h8000_00F0, 32'h1234_5678, 32'h8000_0000, 32'hF0, 32'h3};
		logic [31:0] bv [5] = '{32'h8000_000F, 32'h1234_5678, 32'h1, 32'hF, 32'h1};
		logic [31:0] fv [5] = '{32'hB000_0000, 32'h5000_0000, 32'hB000_0000, 32'h5000_0000,
			32'h3000_0000};
		wr(8'h10, 32'h3000_0000);
		last = dest_data;
		for (int k = 0; k < 5; k++) begin
			exec(cv[k], av[k], bv[k]);
			chk({31'h0, flags_write}, 32'h1);
			chk({31'h0, dest_write}, 32'h0);
			chk(dest_data, last);
			chk(flg(), fv[k]);
			rd(8'h14, 32'h4);
		end
	endtask
	task automatic t_regs();
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, last);
		wr(8'h00, 32'hA5A5_5A5A);
		rd(8'h00, 32'hA5A5_5A5A);
		exec(32'hB, 32'h1, 32'h1);
		chk({30'h0, dest_write, flags_write}, 32'h0);
		chk(flg(), 32'h3000_0000);
		rd(8'h14, 32'h1);
		rd(8'h04, 32'h1);
		rd(8'h10, 32'h3000_0000);
		exec(32'h0, 32'h2, 32'h3);
		chk({30'h0, dest_write, flags_write}, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h0C, last);
		rd(8'h3C, 32'h0);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_lanes();
		t_tests();
		t_regs();
		close_out();
	end
endmodule
